// ---- pis_pkg.sv ----
// package for the power-up initialization sequencer
// assumes a 25 MHz core clock; all counts derive from it
package pis_pkg;

  // ****************************************
  // timing
  // ****************************************
  localparam int unsigned CLK_MHZ          = 25;
  localparam int unsigned RESET_WAIT_US    = 250;
  localparam int unsigned RESET_BUSY_NS    = 1250000;
  localparam int unsigned AUTO_INIT_NS     = 1250000;
  localparam int unsigned RESET_WAIT_CYC   = RESET_WAIT_US * CLK_MHZ;
  localparam int unsigned RESET_BUSY_CYC   = (RESET_BUSY_NS * CLK_MHZ) / 1000;
  localparam int unsigned AUTO_INIT_CYC    = (AUTO_INIT_NS * CLK_MHZ) / 1000;
  localparam int unsigned CNT_W            = 20;

  // ****************************************
  // commands and layout
  // ****************************************
  localparam logic [7:0]  CMD_RESET        = 8'hff;
  localparam logic [7:0]  CMD_STATUS_POLL  = 8'h0f;
  localparam logic [7:0]  STATUS_REG_ADDR  = 8'hc0;
  localparam int unsigned OIP_BIT          = 0;
  localparam logic [15:0] FIRST_PAGE_ADDR  = 16'h0000;

  typedef enum logic [2:0]
  {
    PIS_OFF      = 3'b000,
    PIS_INIT     = 3'b001,
    PIS_LOAD     = 3'b011,
    PIS_READY    = 3'b010,
    PIS_RST_BUSY = 3'b110
  } pis_state_t;

  typedef struct packed
  {
    logic       valid;
    logic [7:0] opcode;
    logic [7:0] addr;
  } pis_cmd_t;

  typedef struct packed
  {
    logic       req;
    logic [15:0] page;
  } pis_load_t;

endpackage : pis_pkg

// ---- pis_timer.sv ----
// cycle down-counter used for the initialization windows
// assumes load and run come from the same clock domain
`timescale 1ns/1ns
module pis_timer
(
  input  wire logic                     clk,
  input  wire logic                     rst_n,
  input  wire logic                     ce,
  input  wire logic                     load,
  input  wire logic [pis_pkg::CNT_W-1:0] value,
  output logic                          done
);
  import pis_pkg::*;

  logic [CNT_W-1:0] cnt_reg;
  logic [CNT_W-1:0] cnt_next;

  always_comb
  begin
    cnt_next = cnt_reg;
    if (load)
      cnt_next = value;
    else if (cnt_reg != '0)
      cnt_next = cnt_reg - 1'b1;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      cnt_reg <= '0;
    else if (ce)
      cnt_reg <= cnt_next;
  end

  assign done = (cnt_reg == '0) && !load;

endmodule : pis_timer

// ---- pis_sequencer.sv ----
// power-up initialization sequencer of a serial nand device
// assumes a decoded command strobe from the spi front end on core_clk
// supply_ok (write-inhibit threshold crossed) and cs_n are raw pins
//
// Operation
// - status poll answered during init; host may poll the busy flag
// - init starts by itself at supply threshold, no reset command needed
// - by default the first page is copied into the cache register
// - first-page auto-load runs regardless of chip select state
`timescale 1ns/1ns
module pis_sequencer
(
  input  wire logic             core_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic             supply_ok,
  input  wire logic             cs_n,
  input  wire logic             autoload_en,
  input  wire pis_pkg::pis_cmd_t cmd,
  input  wire logic             load_done,
  output pis_pkg::pis_load_t    load_req,
  output logic                  operation_in_progress_flag,
  output logic [7:0]            status_poll_data,
  output logic                  status_poll_valid,
  output logic                  ready,
  output logic                  early_cmd_err
);
  import pis_pkg::*;

  // ****************************************
  // reset release and pin synchronisers
  // ****************************************
  logic [1:0] rst_sync_reg;
  logic       rst_core_n;

  always_ff @(posedge core_clk or negedge rst_n)
  begin
    if (!rst_n)
      rst_sync_reg <= 2'b00;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end

  assign rst_core_n = rst_sync_reg[1];

  logic [1:0] sup_sync_reg;
  logic [1:0] cs_sync_reg;
  logic       supply_s;

  always_ff @(posedge core_clk or negedge rst_core_n)
  begin
    if (!rst_core_n)
    begin
      sup_sync_reg <= 2'b00;
      cs_sync_reg  <= 2'b11;
    end
    else if (clk_en)
    begin
      sup_sync_reg <= {sup_sync_reg[0], supply_ok};
      cs_sync_reg  <= {cs_sync_reg[0], cs_n};
    end
  end

  assign supply_s = sup_sync_reg[1];

  // ****************************************
  // sequencer
  // ****************************************
  pis_state_t       state_reg;
  pis_state_t       state_next;
  logic             tmr_load;
  logic [CNT_W-1:0] tmr_value;
  logic             tmr_done;
  pis_load_t        load_reg;
  pis_load_t        load_next;
  logic             oip_reg;
  logic             oip_next;
  logic             ready_reg;
  logic             ready_next;
  logic             err_reg;
  logic             err_next;
  logic             is_reset;
  logic             is_poll;

  assign is_reset = cmd.valid && (cmd.opcode == CMD_RESET);
  assign is_poll  = cmd.valid && (cmd.opcode == CMD_STATUS_POLL)
                    && (cmd.addr == STATUS_REG_ADDR);

  pis_timer u_timer
  (
    .clk   (core_clk),
    .rst_n (rst_core_n),
    .ce    (clk_en),
    .load  (tmr_load),
    .value (tmr_value),
    .done  (tmr_done)
  );

  always_comb
  begin
    state_next = state_reg;
    load_next  = load_reg;
    oip_next   = oip_reg;
    ready_next = ready_reg;
    err_next   = 1'b0;
    tmr_load   = 1'b0;
    tmr_value  = CNT_W'(AUTO_INIT_CYC);
    case (state_reg)
      PIS_OFF:
      begin
        oip_next   = 1'b1;
        ready_next = 1'b0;
        if (supply_s)
        begin
          state_next = PIS_INIT;
          tmr_load   = 1'b1;
          tmr_value  = CNT_W'(AUTO_INIT_CYC);
        end
      end
      PIS_INIT:
      begin
        // chip select is deliberately not looked at here
        if (tmr_done)
        begin
          if (autoload_en)
          begin
            state_next    = PIS_LOAD;
            load_next.req  = 1'b1;
            load_next.page = FIRST_PAGE_ADDR;
          end
          else
          begin
            state_next = PIS_READY;
            oip_next   = 1'b0;
            ready_next = 1'b1;
          end
        end
      end
      PIS_LOAD:
      begin
        if (load_done)
        begin
          load_next.req = 1'b0;
          state_next    = PIS_READY;
          oip_next      = 1'b0;
          ready_next    = 1'b1;
        end
      end
      PIS_READY:
      begin
        if (is_reset)
        begin
          state_next = PIS_RST_BUSY;
          oip_next   = 1'b1;
          ready_next = 1'b0;
          tmr_load   = 1'b1;
          tmr_value  = CNT_W'(RESET_BUSY_CYC);
        end
      end
      PIS_RST_BUSY:
      begin
        if (tmr_done)
        begin
          state_next = PIS_READY;
          oip_next   = 1'b0;
          ready_next = 1'b1;
        end
      end
      default:
        state_next = PIS_OFF;
    endcase
    // a command other than a poll while busy is flagged, not obeyed
    if (oip_reg && cmd.valid && !is_poll && !(state_reg == PIS_READY))
      err_next = 1'b1;
    // supply collapse sends the sequencer back to PIS_OFF, busy, not ready, no load request
    if (!supply_s)
    begin
      state_next    = PIS_OFF;
      load_next.req = 1'b0;
      oip_next      = 1'b1;
      ready_next    = 1'b0;
    end
  end

  always_ff @(posedge core_clk or negedge rst_core_n)
  begin
    if (!rst_core_n)
    begin
      state_reg <= PIS_OFF;
      load_reg  <= '0;
      oip_reg   <= 1'b1;
      ready_reg <= 1'b0;
      err_reg   <= 1'b0;
    end
    else if (clk_en)
    begin
      state_reg <= state_next;
      load_reg  <= load_next;
      oip_reg   <= oip_next;
      ready_reg <= ready_next;
      err_reg   <= err_next;
    end
  end

  // ****************************************
  // status poll answer
  // ****************************************
  logic [7:0] poll_data_reg;
  logic [7:0] poll_data_next;
  logic       poll_vld_reg;
  logic       poll_vld_next;

  always_comb
  begin
    poll_data_next = poll_data_reg;
    poll_vld_next  = 1'b0;
    if (is_poll)
    begin
      poll_data_next          = 8'h00;
      poll_data_next[OIP_BIT] = oip_reg;
      poll_vld_next           = 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rst_core_n)
  begin
    if (!rst_core_n)
    begin
      poll_data_reg <= 8'h00;
      poll_vld_reg  <= 1'b0;
    end
    else if (clk_en)
    begin
      poll_data_reg <= poll_data_next;
      poll_vld_reg  <= poll_vld_next;
    end
  end

  assign load_req                   = load_reg;
  assign operation_in_progress_flag = oip_reg;
  assign status_poll_data           = poll_data_reg;
  assign status_poll_valid          = poll_vld_reg;
  assign ready                      = ready_reg;
  assign early_cmd_err              = err_reg;

endmodule : pis_sequencer

// ---- pis_sequencer_props.sv ----
// checker for the power-up initialization sequencer ports
// assumes one clock domain and the async active-low reset pin
`timescale 1ns/1ns
module pis_sequencer_props
(
  input wire logic               core_clk,
  input wire logic               rst_n,
  input wire logic               clk_en,
  input wire logic               autoload_en,
  input wire pis_pkg::pis_cmd_t  cmd,
  input wire logic               load_done,
  input wire pis_pkg::pis_load_t load_req,
  input wire logic               operation_in_progress_flag,
  input wire logic [7:0]         status_poll_data,
  input wire logic               status_poll_valid,
  input wire logic               ready,
  input wire logic               early_cmd_err
);
  import pis_pkg::*;

  // ****************************************
  // properties
  // ****************************************
  // a frozen core answers nothing, so the next-cycle checks on poll answer, ready and error flag need clk_en
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  a_poll_answered: assert property (clk_en && cmd.valid
    && cmd.opcode == CMD_STATUS_POLL && cmd.addr == STATUS_REG_ADDR
    |=> status_poll_valid) else $error("poll not answered");
  a_poll_busy_bit: assert property (status_poll_valid
    |-> status_poll_data == {7'h00, $past(operation_in_progress_flag)})
    else $error("poll data wrong");
  a_load_first_page: assert property (load_req.req
    |-> load_req.page == FIRST_PAGE_ADDR && operation_in_progress_flag)
    else $error("load request wrong");
  a_load_only_enabled: assert property ($rose(load_req.req) |-> autoload_en)
    else $error("load without enable");
  a_ready_not_busy: assert property (ready |-> !operation_in_progress_flag)
    else $error("ready while busy");
  a_busy_through_load: assert property (load_req.req && !load_done
    |=> operation_in_progress_flag && !ready) else $error("busy dropped early");
  a_ready_after_load: assert property (clk_en && load_req.req && load_done
    |=> ready) else $error("no ready after load");
  a_early_cmd_flag: assert property (clk_en && cmd.valid
    && cmd.opcode != CMD_STATUS_POLL && operation_in_progress_flag
    |=> early_cmd_err) else $error("early cmd not flagged");
endmodule : pis_sequencer_props

bind pis_sequencer pis_sequencer_props u_props
(
  .core_clk                   (core_clk),
  .rst_n                      (rst_n),
  .clk_en                     (clk_en),
  .autoload_en                (autoload_en),
  .cmd                        (cmd),
  .load_done                  (load_done),
  .load_req                   (load_req),
  .operation_in_progress_flag (operation_in_progress_flag),
  .status_poll_data           (status_poll_data),
  .status_poll_valid          (status_poll_valid),
  .ready                      (ready),
  .early_cmd_err              (early_cmd_err)
);

// ---- pis_host_model.sv ----
// behavioural spi host: turns a send pulse into a decoded command
// assumes send and opcode change at the falling clock edge
`timescale 1ns/1ns
module pis_host_model
(
  input  wire logic        core_clk,
  input  wire logic        send,
  input  wire logic [7:0]  opcode,
  output pis_pkg::pis_cmd_t cmd
);
  import pis_pkg::*;

  // ****************************************
  // command drive
  // ****************************************
  logic [7:0] op_reg = 8'h00;
  always @(posedge core_clk) if (send) op_reg <= opcode;
  // idle bus shows inverted data so stale values never look valid
  assign cmd = '{send, send ? opcode : ~op_reg,
                 send ? STATUS_REG_ADDR : ~STATUS_REG_ADDR};
endmodule : pis_host_model

// ---- pis_sequencer_tb.sv ----
// self-checking bench for the power-up initialization sequencer
// assumes the package counts; one run takes about 94k cycles
`timescale 1ns/1ns
module pis_sequencer_tb;
  import pis_pkg::*;
  // ****************************************
  // stimulus and checks
  // ****************************************
  logic core_clk = 0, rst_n = 0, supply_ok = 0, cs_n = 1, load_done = 0, send = 0;
  logic clk_en = 1, autoload_en = 1, req_seen = 0;
  logic [7:0] op = 8'h00, pd;
  logic       flag, pv, rdy, err;
  pis_cmd_t   cmd;
  pis_load_t  lreq;
  int         error_cnt = 0, n_compared = 0, n;
  always #20 core_clk = ~core_clk;
  // remembers any load request since the last reset
  always @(negedge core_clk)
    if (!rst_n)
      req_seen = 1'b0;
    else if (lreq.req === 1'b1)
      req_seen = 1'b1;
  pis_host_model host (.core_clk(core_clk), .send(send), .opcode(op), .cmd(cmd));
  pis_sequencer DUT (.core_clk(core_clk), .rst_n(rst_n), .clk_en(clk_en),
    .supply_ok(supply_ok), .cs_n(cs_n), .autoload_en(autoload_en), .cmd(cmd),
    .load_done(load_done), .load_req(lreq), .operation_in_progress_flag(flag),
    .status_poll_data(pd), .status_poll_valid(pv), .ready(rdy), .early_cmd_err(err));
  task results;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : results
  task chk(input logic got, input logic exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %b", $time, got);
    end
  endtask : chk
  task chk_byte(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk_byte
  task chk_range(input int got, input int lo, input int hi);
    n_compared++;
    if (got < lo || got > hi)
    begin
      error_cnt++;
      $display("wrong value at %0t: count %0d", $time, got);
    end
  endtask : chk_range
  task send_cmd(input logic [7:0] o);
    @(negedge core_clk);
    send = 1;
    op = o;
    @(negedge core_clk);
    send = 0;
  endtask : send_cmd
  // bounded wait on load request or ready
  task wait_for(input bit rq);
    n = 0;
    while ((rq ? lreq.req : rdy) !== 1'b1)
    begin
      @(negedge core_clk);
      n++;
      if (n > 40000)
      begin
        error_cnt++;
        results();
      end
    end
  endtask : wait_for
  task t_auto_init;
    @(negedge core_clk);
    supply_ok = 1;
    repeat (1000) @(negedge core_clk) cs_n = ~cs_n;
    send_cmd(CMD_STATUS_POLL);
    chk(pv, 1);
    chk_byte(pd, 8'h01);
    // reset far too early: must be refused and flagged
    send_cmd(CMD_RESET);
    chk(err, 1);
    wait_for(1);
    chk_range(n + 1004, AUTO_INIT_CYC, AUTO_INIT_CYC + 6);
    chk(lreq.page === FIRST_PAGE_ADDR, 1);
    // slow array: busy must outlast the copy
    repeat (40) @(negedge core_clk);
    chk(req_seen, 1);
    chk(flag, 1);
    chk(rdy, 0);
    load_done = 1;
    @(negedge core_clk);
    load_done = 0;
    chk(rdy, 1);
    chk(flag, 0);
    chk(lreq.req, 0);
    send_cmd(CMD_STATUS_POLL);
    chk(pv, 1);
    chk_byte(pd, 8'h00);
  endtask : t_auto_init
  task t_reset_cmd;
    send_cmd(CMD_RESET);
    chk(flag, 1);
    chk(rdy, 0);
    wait_for(0);
    chk_range(n, RESET_BUSY_CYC - 3, RESET_BUSY_CYC + 3);
    chk(flag, 0);
  endtask : t_reset_cmd
  // mid-run reset, then init without the first-page copy
  task t_no_autoload;
    @(negedge core_clk);
    rst_n = 0;
    autoload_en = 0;
    repeat (2) @(negedge core_clk);
    chk(flag, 1);
    chk(rdy, 0);
    chk(lreq.req, 0);
    chk(err, 0);
    rst_n = 1;
    wait_for(0);
    chk_range(n, AUTO_INIT_CYC, AUTO_INIT_CYC + 8);
    chk(req_seen, 0);
    chk(flag, 0);
    send_cmd(CMD_STATUS_POLL);
    chk(pv, 1);
    chk_byte(pd, 8'h00);
    // let the answer pulse end before freezing the core
    @(negedge core_clk);
    clk_en = 0;
    send_cmd(CMD_STATUS_POLL);
    chk(pv, 0);
    clk_en = 1;
  endtask : t_no_autoload
  initial
  begin
    repeat (5) @(negedge core_clk);
    rst_n = 1;
    repeat (4) @(negedge core_clk);
    t_auto_init();
    t_reset_cmd();
    t_no_autoload();
    results();
  end
endmodule : pis_sequencer_tb
